// >>> asolc_core.sv
// analog speed setpoint and open loop current control with an apb register file
`timescale 1ns/1ns
module asolc_core
#(
    parameter int CYCLES_PER_MS = asolc_pkg::CYCLES_PER_MS
)
(
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic [31:0]                 prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic [3:0]             mode_switch,
    input  wire logic                   drive_enable_in,
    input  wire logic                   direction_in,
    input  wire logic [11:0]            analog_level,
    output asolc_pkg::asolc_drive_t     drive
);

    // decode of the four-bit mode switch
    function automatic asolc_pkg::asolc_mode_t decode_switch(input logic [3:0] code);
        asolc_pkg::asolc_mode_t m;
        m          = '0;
        m.closed   = code[3];
        m.analog   = code[2];
        m.joystick = code[2] && code[1];
        m.slow     = code[2] && code[0];
        m.test_run = !code[2] && code[1];
        m.test_ccw = !code[2] && code[1] && code[0];
        return m;
    endfunction

    // register state
    logic [3:0]  submode;
    logic [7:0]  opmode;
    logic [7:0]  homing;
    logic [15:0] maxcur;
    logic [15:0] rated_ma;
    logic [15:0] protect_ma;
    logic [7:0]  poles;
    logic [15:0] idle_ms;
    logic [15:0] reduced_ma;
    logic        special_on;
    logic [3:0]  switch_code;
    logic        strap_taken;

    // bus decode
    wire setup   = psel && !penable;
    wire access  = psel && penable;
    wire wr      = access && pwrite;

    // one address compare per register word
    wire hit_submode = (paddr == asolc_pkg::OFS_SUBMODE);
    wire hit_opmode  = (paddr == asolc_pkg::OFS_OPMODE);
    wire hit_homing  = (paddr == asolc_pkg::OFS_HOMING);
    wire hit_maxcur  = (paddr == asolc_pkg::OFS_MAXCUR);
    wire hit_rated   = (paddr == asolc_pkg::OFS_RATED);
    wire hit_protect = (paddr == asolc_pkg::OFS_PROTECT);
    wire hit_poles   = (paddr == asolc_pkg::OFS_POLES);
    wire hit_idle    = (paddr == asolc_pkg::OFS_IDLE);
    wire hit_reduced = (paddr == asolc_pkg::OFS_REDUCED);
    wire hit_special = (paddr == asolc_pkg::OFS_SPECIAL);
    wire hit_status  = (paddr == asolc_pkg::OFS_STATUS);
    wire hit_vel     = (paddr == asolc_pkg::OFS_VEL);
    wire hit_cur     = (paddr == asolc_pkg::OFS_CUR);
    wire hit_field   = (paddr == asolc_pkg::OFS_FIELD);

    // writable words and read-only words
    wire hit_rw      = hit_submode
                       || hit_opmode
                       || hit_homing
                       || hit_maxcur
                       || hit_rated
                       || hit_protect
                       || hit_poles
                       || hit_idle
                       || hit_reduced
                       || hit_special;
    wire hit_ro      = hit_status
                       || hit_vel
                       || hit_cur
                       || hit_field;

    // loop type and mode checks
    wire open_loop   = !submode[asolc_pkg::SUB_LOOP_BIT];
    wire cut_enabled = submode[asolc_pkg::SUB_CUT_BIT];

    // values that open loop cannot honour
    wire [7:0] wr_byte = pwdata[7:0];
    wire torque_req  = (wr_byte == asolc_pkg::OPM_PROF_TRQ) || (wr_byte == asolc_pkg::OPM_CYC_TRQ);
    wire block_req   = (wr_byte >= asolc_pkg::HOM_BLOCK_MIN);
    wire bad_opmode  = hit_opmode && open_loop && torque_req;
    wire bad_homing  = hit_homing && open_loop && block_req;

    // refused writes answer with an error
    wire refuse_wr   = pwrite && (hit_ro || bad_opmode || bad_homing);
    wire unmapped    = !(hit_rw || hit_ro);

    // zero wait state slave; errors for unmapped or refused accesses
    // the slave never stretches an access
    assign pready  = 1'b1;
    assign pslverr = access && (unmapped || refuse_wr);

    // maximum current setting clamped to 100 percent
    // larger settings store the ceiling
    wire [15:0] maxcur_clamped = (pwdata[15:0] > asolc_pkg::PERMILLE_FULL)
                                 ? asolc_pkg::PERMILLE_FULL : pwdata[15:0];

    // strap capture of the mode switch at the first edge after reset release
    // a moved switch waits for the next restart
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            strap_taken <= 1'b0;
            switch_code <= 4'h0;
        end
        else if (!strap_taken)
        begin
            strap_taken <= 1'b1;
            switch_code <= mode_switch;
        end
    end

    // submode register: strap seeds the loop bit, software may change it later
    // no bus write can land on the seeding edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            submode <= asolc_pkg::RST_SUBMODE;
        else if (!strap_taken && special_on)
            submode[asolc_pkg::SUB_LOOP_BIT] <= mode_switch[3];
        else if (wr && hit_submode)
            submode <= pwdata[3:0];
    end

    // operating mode and homing method, refused values leave the old setting
    // pslverr tells software the write was refused
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            opmode <= asolc_pkg::RST_OPMODE;
            homing <= asolc_pkg::RST_HOMING;
        end
        else if (wr)
        begin
            if (hit_opmode && !bad_opmode)
                opmode <= wr_byte;
            if (hit_homing && !bad_homing)
                homing <= wr_byte;
        end
    end

    // current and motor configuration, currents in milliamperes, maxcur in tenths of a percent
    // special_on low parks every special mode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            maxcur     <= asolc_pkg::RST_MAXCUR;
            rated_ma   <= asolc_pkg::RST_RATED;
            protect_ma <= asolc_pkg::RST_PROTECT;
            poles      <= asolc_pkg::RST_POLES;
            idle_ms    <= asolc_pkg::RST_IDLE;
            reduced_ma <= asolc_pkg::RST_REDUCED;
            special_on <= 1'b1;
        end
        else if (wr)
        begin
            if (hit_maxcur)
                maxcur <= maxcur_clamped;
            if (hit_rated)
                rated_ma <= pwdata[15:0];
            if (hit_protect)
                protect_ma <= pwdata[15:0];
            if (hit_poles)
                poles <= pwdata[7:0];
            if (hit_idle)
                idle_ms <= pwdata[15:0];
            if (hit_reduced)
                reduced_ma <= pwdata[15:0];
            if (hit_special)
                special_on <= pwdata[0];
        end
    end

    // effective mode from the captured switch
    asolc_pkg::asolc_mode_t mode;
    assign mode = decode_switch(switch_code);

    // enable is the pin gated by special_on; no other control word path exists
    wire enabled = special_on && drive_enable_in;

    // speed limit, slow for odd analog codes
    wire [15:0] vmax = mode.slow ? asolc_pkg::SPEED_SLOW : asolc_pkg::SPEED_FAST;

    // normal mode: dead zone at the bottom, linear above its edge
    // below the edge the difference wraps; norm_dead masks it
    wire        norm_dead = (analog_level <= asolc_pkg::ADC_DEAD);
    wire [27:0] norm_num  = 28'(analog_level - asolc_pkg::ADC_DEAD) * 28'(vmax);
    wire [27:0] norm_mag  = norm_num / 28'(asolc_pkg::ADC_FULL - asolc_pkg::ADC_DEAD);

    // joystick mode: dead zone around half scale, linear on each side
    // each half has its own span and divisor
    wire [11:0] joy_hi_edge = asolc_pkg::ADC_HALF + asolc_pkg::ADC_DEAD;
    wire [11:0] joy_lo_edge = asolc_pkg::ADC_HALF - asolc_pkg::ADC_DEAD;
    wire        joy_pos     = (analog_level > joy_hi_edge);
    wire        joy_neg     = (analog_level < joy_lo_edge);
    wire [27:0] joy_pos_num = 28'(analog_level - joy_hi_edge) * 28'(vmax);
    wire [27:0] joy_neg_num = 28'(joy_lo_edge - analog_level) * 28'(vmax);
    wire [27:0] joy_pos_mag = joy_pos_num / 28'(asolc_pkg::ADC_FULL - joy_hi_edge);
    wire [27:0] joy_neg_mag = joy_neg_num / 28'(joy_lo_edge);

    // signed speed candidates
    // direction high turns counterclockwise in normal mode; joystick mode ignores it
    wire signed [15:0] norm_mag_s = $signed(norm_mag[15:0]);
    wire signed [15:0] norm_speed = norm_dead ? 16'sh0
                                    : (direction_in ? -norm_mag_s : norm_mag_s);
    wire signed [15:0] joy_speed  = joy_pos ? $signed(joy_pos_mag[15:0])
                                    : (joy_neg ? -$signed(joy_neg_mag[15:0])
                                    : 16'sh0);
    wire signed [15:0] test_speed = mode.test_ccw ? -$signed(asolc_pkg::SPEED_TEST)
                                    : $signed(asolc_pkg::SPEED_TEST);

    // select the setpoint; nothing moves without the enable pin
    wire signed [15:0] next_velocity = !enabled      ? 16'sh0
                                     : mode.analog   ? (mode.joystick ? joy_speed : norm_speed)
                                     : mode.test_run ? test_speed
                                     : 16'sh0;

    // full set current: rated times clamped per mille, capped by the protective limit
    wire [31:0] full_prod = 32'(rated_ma) * 32'(maxcur);
    wire [31:0] full_div  = full_prod / 32'(asolc_pkg::PERMILLE_FULL);
    wire [15:0] full_ma   = (full_div > 32'(protect_ma)) ? protect_ma : full_div[15:0];

    // reduced value never exceeds the full one
    wire [15:0] cut_ma    = (reduced_ma < full_ma) ? reduced_ma : full_ma;

    // standstill is judged on the set value, not on motion
    // both held and next set value must be zero
    wire standstill = (drive.velocity == 16'sh0) && (next_velocity == 16'sh0);
    wire reduce;

    // idle timer, open loop with reduction on
    asolc_idle_timer
    #(
        .CYCLES_PER_MS (CYCLES_PER_MS)
    )
    u_idle
    (
        .pclk       (pclk),
        .presetn    (presetn),
        .standstill (standstill),
        .armed      (open_loop && cut_enabled),
        .idle_ms    (idle_ms),
        .reduce     (reduce)
    );

    // leaving standstill drops reduction in the same cycle
    wire               cut_now       = reduce && (next_velocity == 16'sh0);
    wire [15:0]        next_current  = cut_now ? cut_ma : full_ma;

    // field rate is set speed times pole pairs
    wire signed [31:0] field_prod    = 32'(next_velocity) * $signed({24'h0, poles});
    wire signed [23:0] next_field    = field_prod[23:0];

    // motor command register: enable, velocity setpoint, set current, reduction flag and field rate
    // one stable word per cycle toward the stage
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            drive <= '0;
        else
        begin
            drive.enable     <= enabled;
            drive.velocity   <= next_velocity;
            drive.current_ma <= next_current;
            drive.reduced    <= cut_now;
            drive.field_rate <= next_field;
        end
    end

    // read mux
    wire [31:0] status_word = {24'h0, open_loop, drive.reduced, drive.enable, special_on, switch_code};

    // narrow fields low, signed words extended
    wire [31:0] next_rdata  = hit_submode ? {28'h0, submode}
                            : hit_opmode  ? {24'h0, opmode}
                            : hit_homing  ? {24'h0, homing}
                            : hit_maxcur  ? {16'h0, maxcur}
                            : hit_rated   ? {16'h0, rated_ma}
                            : hit_protect ? {16'h0, protect_ma}
                            : hit_poles   ? {24'h0, poles}
                            : hit_idle    ? {16'h0, idle_ms}
                            : hit_reduced ? {16'h0, reduced_ma}
                            : hit_special ? {31'h0, special_on}
                            : hit_status  ? status_word
                            : hit_vel     ? {{16{drive.velocity[15]}}, drive.velocity}
                            : hit_cur     ? {16'h0, drive.current_ma}
                            : hit_field   ? {{8{drive.field_rate[23]}}, drive.field_rate}
                            : 32'h0;

    // read data is latched in the setup cycle and stands through the access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0;
        else if (setup && !pwrite)
            prdata <= next_rdata;
    end

endmodule // asolc_core

// >>> asolc_core_asserts.sv
// checker: concurrent assertions on the speed path and drive outputs
`timescale 1ns/1ns
module asolc_core_asserts
(
    input wire logic                    pclk,
    input wire logic                    presetn,
    input wire logic [3:0]              mode_switch,
    input wire logic                    drive_enable_in,
    input wire logic                    direction_in,
    input wire logic [11:0]             analog_level,
    input wire asolc_pkg::asolc_drive_t drive
);
    logic [1:0]         up_cnt;
    logic signed [15:0] vmax;
    logic               up;
    logic               nrm;
    logic               joy;
    // mode decode; the strap only counts once it has been captured after reset
    assign up   = (up_cnt == 2'h3);
    assign nrm  = up && drive_enable_in && (mode_switch[2:1] == 2'h2);
    assign joy  = up && drive_enable_in && (mode_switch[2:1] == 2'h3);
    assign vmax = mode_switch[0] ? $signed(asolc_pkg::SPEED_SLOW) : $signed(asolc_pkg::SPEED_FAST);
    // cycles since reset release, saturating
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            up_cnt <= 2'h0;
        else if (!up)
            up_cnt <= up_cnt + 2'h1;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_no_enable: assert property (up && !drive_enable_in |=> drive.velocity == 0 && !drive.enable)
        else $error("drive moves without enable pin");
    a_dead_normal: assert property (nrm && analog_level <= asolc_pkg::ADC_DEAD |=> drive.velocity == 0)
        else $error("normal dead zone not zero");
    a_dir_sense: assert property (nrm && analog_level > 12'h0ff |=> (drive.velocity < 0) == $past(direction_in))
        else $error("rotation sense wrong");
    a_full_scale: assert property (nrm && analog_level == 12'hfff && !direction_in |=> drive.velocity == vmax)
        else $error("full scale not maximum speed");
    a_joy_zero: assert property (joy && analog_level >= 12'h7f7 && analog_level <= 12'h809 |=> drive.velocity == 0)
        else $error("joystick centre not zero");
    a_joy_pos: assert property (joy && analog_level > 12'h900 |=> drive.velocity > 0)
        else $error("joystick upper half not positive");
    a_joy_neg: assert property (joy && analog_level < 12'h700 |=> drive.velocity < 0)
        else $error("joystick lower half not negative");
    a_test_speed: assert property (up && drive_enable_in && mode_switch[2:1] == 2'h1 |=>
        drive.enable && drive.velocity == (mode_switch[0] ? -16'sh001e : 16'sh001e))
        else $error("test run speed wrong");
    a_reduce_clear: assert property (drive.velocity != 0 |-> !drive.reduced)
        else $error("reduced current while moving");
endmodule // asolc_core_asserts

bind asolc_core asolc_core_asserts chk_u (.pclk(pclk), .presetn(presetn), .mode_switch(mode_switch),
    .drive_enable_in(drive_enable_in), .direction_in(direction_in), .analog_level(analog_level), .drive(drive));

// >>> asolc_core_bench.sv
// bench: self-checking testbench for the analog speed and current block
`timescale 1ns/1ns
module asolc_core_bench;
    logic                    pclk            = 1'b0;
    logic                    presetn         = 1'b0;
    logic                    psel            = 1'b0;
    logic                    penable         = 1'b0;
    logic                    pwrite          = 1'b0;
    logic [7:0]              paddr           = 8'h00;
    logic [31:0]             pwdata          = 32'h0;
    logic [3:0]              mode_switch     = 4'h4;
    logic                    drive_enable_in = 1'b0;
    logic                    direction_in    = 1'b0;
    logic [11:0]             analog_level    = 12'h000;
    logic [31:0]             prdata;
    logic                    pready;
    logic                    pslverr;
    asolc_pkg::asolc_drive_t drive;
    asolc_pkg::asolc_drive_t dv;
    logic signed [39:0]      angle;
    logic                    sgn;
    logic [31:0]             rd;
    logic                    er;
    int                      err_total       = 0;
    int                      checks          = 0;
    localparam logic signed [15:0] VTAB [8] = '{16'h0, 16'h0, 16'h1e, 16'hffe2, 16'h3e8, 16'h64, 16'h3e8, 16'h64};
    localparam logic [32:0] ROWS [11] = '{{4'h4, 12'h000, 1'b0, 16'h0}, {4'h4, 12'h009, 1'b0, 16'h0},
        {4'h4, 12'h804, 1'b0, 16'h1f4}, {4'h4, 12'h804, 1'b1, 16'hfe0c}, {4'h4, 12'hfff, 1'b1, 16'hfc18},
        {4'h7, 12'h7f7, 1'b0, 16'h0}, {4'h7, 12'h809, 1'b1, 16'h0}, {4'h7, 12'h800, 1'b0, 16'h0},
        {4'h7, 12'hfff, 1'b1, 16'h64}, {4'h7, 12'h000, 1'b0, 16'hff9c}, {4'h7, 12'hc00, 1'b0, 16'h31}};
    localparam logic [39:0] REGS [10] = '{{8'h00, 32'h0}, {8'h04, 32'h2}, {8'h08, 32'h11}, {8'h0c, 32'h3e8},
        {8'h10, 32'h3e8}, {8'h14, 32'h7d0}, {8'h18, 32'h32}, {8'h1c, 32'h3e8}, {8'h20, 32'h1f4}, {8'h24, 32'h1}};
    // design with a four-cycle millisecond, and the motor on its far side
    asolc_core #(.CYCLES_PER_MS(4)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mode_switch(mode_switch), .drive_enable_in(drive_enable_in), .direction_in(direction_in),
        .analog_level(analog_level), .drive(drive));
    asolc_motor_model motor_u (.pclk(pclk), .presetn(presetn), .drive(drive), .angle(angle));
    // 250 MHz clock
    initial forever #2 pclk = ~pclk;
    task automatic final_report;
        if (err_total == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rst(input logic [3:0] sw);
        presetn         <= 1'b0;
        mode_switch     <= sw;
        drive_enable_in <= 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 16)
        begin
            err_total++;
            $display("mismatch %0t bus timeout", $time);
            final_report();
        end
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
        apb(1'b1, a, d);
        chk(er, e);
    endtask
    task automatic go(input logic [11:0] lvl, input logic dir, input logic en);
        analog_level    <= lvl;
        direction_in    <= dir;
        drive_enable_in <= en;
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        dv  = drive;
        sgn = angle[39];
        @(posedge pclk);
    endtask
    // every switch code at full scale, strap seen in status
    task automatic t_codes;
        for (int i = 0; i < 16; i++)
        begin
            rst(4'(i));
            go(12'hfff, 1'b0, 1'b1);
            chk(dv.velocity, VTAB[i % 8]);
            chk(dv.field_rate, VTAB[i % 8] * 32'sh32);
            chk(dv.current_ma, 16'h3e8);
            chk(sgn, VTAB[i % 8][15]);
            apb(1'b0, asolc_pkg::OFS_STATUS, 32'h0);
            chk({rd[7], rd[3:0]}, {~i[3], i[3:0]});
        end
    endtask
    // normal and joystick levels, then enable withdrawn
    task automatic t_table;
        logic [3:0] sw = 4'h0;
        for (int i = 0; i < 11; i++)
        begin
            if (ROWS[i][32:29] != sw)
                rst(ROWS[i][32:29]);
            sw = ROWS[i][32:29];
            go(ROWS[i][28:17], ROWS[i][16], 1'b1);
            chk(dv.velocity, $signed(ROWS[i][15:0]));
        end
        go(12'hfff, 1'b0, 1'b0);
        chk({dv.enable, dv.velocity}, 32'h0);
    endtask
    // reset values, clamping, scaling and refused writes
    task automatic t_regs;
        rst(4'h4);
        for (int i = 0; i < 10; i++)
        begin
            apb(1'b0, REGS[i][39:32], 32'h0);
            chk(rd, REGS[i][31:0]);
        end
        wr(8'h0c, 32'h7d0, 1'b0);
        apb(1'b0, 8'h0c, 32'h0);
        chk(rd, 32'h3e8);
        wr(8'h0c, 32'h1f4, 1'b0);
        wr(8'h18, 32'h64, 1'b0);
        go(12'hfff, 1'b0, 1'b1);
        chk(dv.current_ma, 16'h1f4);
        chk(dv.field_rate, 32'h186a0);
        apb(1'b0, 8'h2c, 32'h0);
        chk(rd, 32'h3e8);
        wr(8'h14, 32'h190, 1'b0);
        apb(1'b0, 8'h30, 32'h0);
        chk(rd, 32'h190);
        wr(8'h04, 32'h4, 1'b1);
        wr(8'h04, 32'ha, 1'b1);
        wr(8'h08, 32'hfc, 1'b1);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h2);
        wr(8'h28, 32'h0, 1'b1);
        apb(1'b0, 8'h40, 32'h0);
        chk({er, rd[30:0]}, 32'h80000000);
        wr(8'h00, 32'h1, 1'b0);
        wr(8'h04, 32'ha, 1'b0);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'ha);
    endtask
    // standstill reduction after two milliseconds, cleared by motion
    task automatic t_reduce;
        int n = 0;
        rst(4'h4);
        wr(8'h1c, 32'h2, 1'b0);
        wr(8'h00, 32'h8, 1'b0);
        go(12'hfff, 1'b0, 1'b1);
        go(12'h000, 1'b0, 1'b1);
        chk(dv.reduced, 1'b0);
        do
        begin
            @(negedge pclk);
            n++;
        end
        while (drive.reduced !== 1'b1 && n < 40);
        chk(n >= 7 && n <= 10, 1'b1);
        if (n >= 40) final_report();
        chk(drive.current_ma, 16'h1f4);
        @(posedge pclk);
        go(12'hfff, 1'b0, 1'b1);
        chk({dv.reduced, dv.current_ma}, 32'h3e8);
        wr(8'h00, 32'h0, 1'b0);
        go(12'h000, 1'b0, 1'b1);
        repeat (20) @(posedge pclk);
        go(12'h000, 1'b0, 1'b1);
        chk(dv.reduced, 1'b0);
    endtask
    // main sequence
    initial
    begin
        t_codes();
        t_table();
        t_regs();
        t_reduce();
        final_report();
    end
endmodule // asolc_core_bench

// >>> asolc_idle_timer.sv
// standstill idle timer: raises reduce after the set value rests for the programmed milliseconds
`timescale 1ns/1ns
module asolc_idle_timer
#(
    parameter int CYCLES_PER_MS = asolc_pkg::CYCLES_PER_MS
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        standstill,
    input  wire logic        armed,
    input  wire logic [15:0] idle_ms,
    output logic             reduce
);

    logic [31:0] tick_cnt;
    logic [15:0] ms_cnt;
    wire         run      = armed && standstill;
    wire         tick     = (tick_cnt == 32'(CYCLES_PER_MS - 1));
    wire         expired  = (ms_cnt >= idle_ms);

    // millisecond prescaler, cleared the moment motion is commanded
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tick_cnt <= 32'h0;
        else if (!run || tick)
            tick_cnt <= 32'h0;
        else
            tick_cnt <= tick_cnt + 32'h1;
    end

    // idle milliseconds; reduce follows once the count reaches the setting
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ms_cnt <= 16'h0;
            reduce <= 1'b0;
        end
        else if (!run)
        begin
            ms_cnt <= 16'h0;
            reduce <= 1'b0;
        end
        else
        begin
            if (tick && !expired)
                ms_cnt <= ms_cnt + 16'h1;
            reduce <= expired;
        end
    end

endmodule // asolc_idle_timer

// >>> asolc_motor_model.sv
// partner: stepper motor model that integrates the commanded stator field rotation
`timescale 1ns/1ns
module asolc_motor_model
(
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire asolc_pkg::asolc_drive_t drive,
    output logic signed [39:0]           angle
);
    // rotor follows the field with no step loss, and only while the stage is enabled
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            angle <= 40'sh0;
        else if (drive.enable)
            angle <= angle + 40'(drive.field_rate);
endmodule // asolc_motor_model

// >>> asolc_pkg.sv
// package: register map, field layout, reset values and timing constants for the analog speed / current block
package asolc_pkg;

    // clock and time
    localparam int CLK_HZ        = 250000000;
    localparam int MS_PER_S      = 1000;
    localparam int CYCLES_PER_MS = CLK_HZ / MS_PER_S;

    // analog input scaling: full scale is 10 V on a 12 bit converter
    localparam int         ADC_W      = 12;
    localparam int         ADC_STEPS  = 4096;
    localparam int         FULL_MV    = 10000;
    localparam int         DEAD_MV    = 20;
    localparam int         DEAD_CODES = (DEAD_MV * ADC_STEPS + FULL_MV - 1) / FULL_MV;
    localparam logic [11:0] ADC_FULL  = 12'hfff;
    localparam logic [11:0] ADC_HALF  = 12'h800;
    localparam logic [11:0] ADC_DEAD  = 12'(DEAD_CODES);

    // speeds in rpm
    localparam logic [15:0] SPEED_FAST = 16'h03e8;   // 1000 rpm
    localparam logic [15:0] SPEED_SLOW = 16'h0064;   // 100 rpm
    localparam logic [15:0] SPEED_TEST = 16'h001e;   // 30 rpm

    // current scaling, tenths of a percent
    localparam logic [15:0] PERMILLE_FULL = 16'h03e8;

    // register byte offsets
    localparam logic [7:0] OFS_SUBMODE = 8'h00;
    localparam logic [7:0] OFS_OPMODE  = 8'h04;
    localparam logic [7:0] OFS_HOMING  = 8'h08;
    localparam logic [7:0] OFS_MAXCUR  = 8'h0c;
    localparam logic [7:0] OFS_RATED   = 8'h10;
    localparam logic [7:0] OFS_PROTECT = 8'h14;
    localparam logic [7:0] OFS_POLES   = 8'h18;
    localparam logic [7:0] OFS_IDLE    = 8'h1c;
    localparam logic [7:0] OFS_REDUCED = 8'h20;
    localparam logic [7:0] OFS_SPECIAL = 8'h24;
    localparam logic [7:0] OFS_STATUS  = 8'h28;
    localparam logic [7:0] OFS_VEL     = 8'h2c;
    localparam logic [7:0] OFS_CUR     = 8'h30;
    localparam logic [7:0] OFS_FIELD   = 8'h34;

    // submode bit positions
    localparam int SUB_LOOP_BIT = 0;
    localparam int SUB_CUT_BIT  = 3;

    // reset values
    localparam logic [3:0]  RST_SUBMODE = 4'h0;
    localparam logic [7:0]  RST_OPMODE  = 8'h02;
    localparam logic [7:0]  RST_HOMING  = 8'h11;
    localparam logic [15:0] RST_MAXCUR  = 16'h03e8;
    localparam logic [15:0] RST_RATED   = 16'h03e8;
    localparam logic [15:0] RST_PROTECT = 16'h07d0;
    localparam logic [7:0]  RST_POLES   = 8'h32;     // 50 pole pairs, 1.8 degree stepper
    localparam logic [15:0] RST_IDLE    = 16'h03e8;
    localparam logic [15:0] RST_REDUCED = 16'h01f4;

    // operating mode codes
    localparam logic [7:0] OPM_PROF_POS  = 8'h01;
    localparam logic [7:0] OPM_VELOCITY  = 8'h02;
    localparam logic [7:0] OPM_PROF_VEL  = 8'h03;
    localparam logic [7:0] OPM_PROF_TRQ  = 8'h04;
    localparam logic [7:0] OPM_HOMING    = 8'h06;
    localparam logic [7:0] OPM_CYC_TRQ   = 8'h0a;

    // homing methods on a mechanical block are the codes at and above this value
    localparam logic [7:0] HOM_BLOCK_MIN = 8'hfc;

    // decoded mode switch setting
    typedef struct packed {
        logic analog;
        logic joystick;
        logic slow;
        logic test_run;
        logic test_ccw;
        logic closed;
    } asolc_mode_t;

    // command bundle toward the motor stage
    typedef struct packed {
        logic               enable;
        logic               reduced;
        logic signed [15:0] velocity;
        logic [15:0]        current_ma;
        logic signed [23:0] field_rate;
    } asolc_drive_t;

endpackage
